/* File: verilog/rfs_status_regs.sv */
// Framing engine status and transmit setup register bank
//
// How it works
// - Receive-active goes high at the start of a transponder message and stays until its end.
// - Bits 7 to 2 of the FIFO state give the unread byte count, 0 to 32.
// - The FIFO state clears at reset and on the restore-defaults or clear command.
// - A collision stores the full bytes received before it in collision bits 7 to 4.
// - Collision bits 3 to 1 hold the bit offset in the colliding byte, bit 0 reads zero.
// - The collision register clears at reset and on the restore-defaults or clear command.
// - The 10-bit transmit length has its low two bits in 0x0b[7:6], upper eight in 0x0c.
// - Bits 5 to 3 of 0x0b give the valid bits of a final split byte, 000 meaning whole bytes.
// - The 4-bit-reply and anticollision flags clear once the transmission is done.
// - Both transmit length registers are zero at reset and after restore-defaults.
// - Register 0x0d shows the latest 8-bit conversion result, MSB in bit 7.
// - The conversion result clears at reset and after restore-defaults.
`timescale 1ns/10ps
`default_nettype none
`include "rfs_regs.svh"
module rfs_status_regs #(
    parameter int FIFO_DEPTH = `RFS_FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire rfs_pkg::rfs_reg_req_t i_reg,
    input wire logic i_cmd_set_default,
    input wire logic i_cmd_clear,
    input wire rfs_pkg::rfs_frame_evt_t i_evt,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output rfs_pkg::rfs_tx_setup_t o_tx,
    output logic o_rx_active,
    output logic [5:0] o_fifo_fill,
    output logic o_fifo_overflow
);
    import rfs_pkg::*;

    function automatic logic hit(input logic [5:0] addr, input logic [5:0] offset);
        hit = (addr == offset);
    endfunction

    // Reset release synchroniser; first stage read only by the second
    logic rst_meta_reg, rst_n_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    logic rx_active, fifo_ovr;
    logic [5:0] fifo_fill;
    logic fifo_clear;

    assign fifo_clear = i_cmd_set_default | i_cmd_clear;

    rfs_fifo_track #(
        .DEPTH(FIFO_DEPTH),
        .CW(6)
    ) rfs_fifo_track_inst (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n_reg),
        .i_clear(fifo_clear),
        .i_rx_start(i_evt.rx_start),
        .i_rx_end(i_evt.rx_end),
        .i_push(i_evt.fifo_push),
        .i_pop(i_evt.fifo_pop),
        .o_rx_active(rx_active),
        .o_fill(fifo_fill),
        .o_overflow(fifo_ovr)
    );

    logic [7:0] coll_reg, coll_next;
    logic [7:0] txl_reg, txl_next;
    logic [7:0] txh_reg, txh_next;
    logic [7:0] conv_reg, conv_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic wr_low, wr_high;
    logic [7:0] fifo_state;

    assign wr_low = i_reg.wr && hit(i_reg.addr, `RFS_OFF_TX_LEN_LOW);
    assign wr_high = i_reg.wr && hit(i_reg.addr, `RFS_OFF_TX_LEN_HIGH);
    assign fifo_state = {fifo_fill, fifo_ovr, rx_active};

    always_comb begin
        coll_next = coll_reg;
        if (i_cmd_set_default || i_cmd_clear) begin
            coll_next = `RFS_RST_COLLISION;
        end
        // A collision in the same cycle as a clear is kept
        if (i_evt.collision) begin
            coll_next = {i_evt.coll_bytes, i_evt.coll_bits, 1'b0};
        end
    end

    always_comb begin
        txl_next = txl_reg;
        txh_next = txh_reg;
        if (i_evt.tx_done) begin
            txl_next[`RFS_TXL_NIBBLE_BIT] = 1'b0;
            txl_next[`RFS_TXL_ANTICOLL_BIT] = 1'b0;
        end
        // A host write after the transmit ends is new setup, so it wins
        if (wr_low) begin
            txl_next = i_reg.wdata & `RFS_TXL_WR_MASK;
        end
        if (wr_high) begin
            txh_next = i_reg.wdata;
        end
        if (i_cmd_set_default) begin
            txl_next = `RFS_RST_TX_LEN_LOW;
            txh_next = `RFS_RST_TX_LEN_HIGH;
        end
    end

    always_comb begin
        conv_next = conv_reg;
        if (i_cmd_set_default) begin
            conv_next = `RFS_RST_CONV_RESULT;
        end
        if (i_evt.conv_valid) begin
            conv_next = i_evt.conv_data;
        end
    end

    always_comb begin
        rvalid_next = i_reg.rd;
        rdata_next = `RFS_RD_UNMAPPED;
        if (i_reg.rd) begin
            if (hit(i_reg.addr, `RFS_OFF_FIFO_STATE)) begin
                rdata_next = fifo_state;
            end else if (hit(i_reg.addr, `RFS_OFF_COLLISION)) begin
                rdata_next = coll_reg;
            end else if (hit(i_reg.addr, `RFS_OFF_TX_LEN_LOW)) begin
                rdata_next = txl_reg;
            end else if (hit(i_reg.addr, `RFS_OFF_TX_LEN_HIGH)) begin
                rdata_next = txh_reg;
            end else if (hit(i_reg.addr, `RFS_OFF_CONV_RESULT)) begin
                rdata_next = conv_reg;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            coll_reg <= `RFS_RST_COLLISION;
            txl_reg <= `RFS_RST_TX_LEN_LOW;
            txh_reg <= `RFS_RST_TX_LEN_HIGH;
            conv_reg <= `RFS_RST_CONV_RESULT;
            rdata_reg <= `RFS_RD_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else begin
            coll_reg <= coll_next;
            txl_reg <= txl_next;
            txh_reg <= txh_next;
            conv_reg <= conv_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Lengths above 1023 cannot be written, the field is only ten bits
    assign o_tx.tx_length = {txh_reg, txl_reg[`RFS_TXL_LOWER_MSB:`RFS_TXL_LOWER_LSB]};
    assign o_tx.split_byte_bits = txl_reg[`RFS_TXL_SPLIT_MSB:`RFS_TXL_SPLIT_LSB];
    assign o_tx.nibble_reply_expected = txl_reg[`RFS_TXL_NIBBLE_BIT];
    assign o_tx.anticoll_frame = txl_reg[`RFS_TXL_ANTICOLL_BIT];
    assign o_rdata = rdata_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rx_active = rx_active;
    assign o_fifo_fill = fifo_fill;
    assign o_fifo_overflow = fifo_ovr;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n_reg);

    property p_rx_active;
        i_evt.rx_start && !rx_active && !fifo_clear |=> rx_active;
    endproperty
    a_rx_active: assert property (p_rx_active) else $error("rx active not set");

    property p_rx_hold;
        rx_active && !i_evt.rx_end && !fifo_clear |=> rx_active;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx active dropped early");

    property p_overflow;
        fifo_fill == 6'h20 && i_evt.fifo_push && !i_evt.fifo_pop && !fifo_clear
            |=> fifo_ovr && fifo_fill == 6'h20;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_fill_range;
        fifo_fill <= 6'h20;
    endproperty
    a_fill_range: assert property (p_fill_range) else $error("fill count above 32");

    property p_fifo_clear;
        fifo_clear && !i_evt.fifo_push && !i_evt.rx_start |=> fifo_state == 8'h00;
    endproperty
    a_fifo_clear: assert property (p_fifo_clear) else $error("fifo state not cleared");

    property p_coll_store;
        i_evt.collision |=> coll_reg[7:4] == $past(i_evt.coll_bytes)
            && coll_reg[3:1] == $past(i_evt.coll_bits);
    endproperty
    a_coll_store: assert property (p_coll_store) else $error("collision not stored");

    property p_coll_bit0;
        !coll_reg[0];
    endproperty
    a_coll_bit0: assert property (p_coll_bit0) else $error("collision bit 0 set");

    property p_coll_clear;
        i_cmd_clear && !i_evt.collision |=> coll_reg == 8'h00;
    endproperty
    a_coll_clear: assert property (p_coll_clear) else $error("collision not cleared");

    property p_len_high;
        wr_high && !i_cmd_set_default |=> o_tx.tx_length[9:2] == $past(i_reg.wdata);
    endproperty
    a_len_high: assert property (p_len_high) else $error("length high mismatch");

    property p_split;
        wr_low && !i_cmd_set_default |=> o_tx.split_byte_bits == $past(i_reg.wdata[5:3])
            && o_tx.tx_length[1:0] == $past(i_reg.wdata[7:6]);
    endproperty
    a_split: assert property (p_split) else $error("split bits mismatch");

    property p_flags_done;
        i_evt.tx_done && !wr_low |=> !o_tx.nibble_reply_expected && !o_tx.anticoll_frame;
    endproperty
    a_flags_done: assert property (p_flags_done) else $error("frame flags not cleared");

    property p_default;
        i_cmd_set_default && !i_evt.conv_valid |=> o_tx.tx_length == 10'h000
            && txl_reg == 8'h00 && conv_reg == 8'h00;
    endproperty
    a_default: assert property (p_default) else $error("defaults not restored");

    property p_conv;
        i_evt.conv_valid ##1 (i_reg.rd && hit(i_reg.addr, `RFS_OFF_CONV_RESULT))
            |=> o_rdata == $past(i_evt.conv_data, 2);
    endproperty
    a_conv: assert property (p_conv) else $error("conversion result not read");

    property p_rx_idle;
        !rx_active && !i_evt.rx_start |=> !rx_active;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("rx active set without start");

    property p_ovr_sticky;
        fifo_ovr && !fifo_clear |=> fifo_ovr;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overflow dropped");

    property p_fill_push;
        fifo_fill < 6'h20 && i_evt.fifo_push && !i_evt.fifo_pop && !fifo_clear
            |=> fifo_fill == $past(fifo_fill) + 6'h01;
    endproperty
    a_fill_push: assert property (p_fill_push) else $error("fill count not raised");

    property p_fill_pop;
        fifo_fill != 6'h00 && i_evt.fifo_pop && !i_evt.fifo_push && !fifo_clear
            |=> fifo_fill == $past(fifo_fill) - 6'h01;
    endproperty
    a_fill_pop: assert property (p_fill_pop) else $error("fill count not lowered");

    property p_fifo_read;
        i_reg.rd && hit(i_reg.addr, `RFS_OFF_FIFO_STATE)
            |=> o_rdata == {$past(fifo_fill), $past(fifo_ovr), $past(rx_active)};
    endproperty
    a_fifo_read: assert property (p_fifo_read) else $error("fifo state read wrong");

    property p_coll_default;
        i_cmd_set_default && !i_evt.collision |=> coll_reg == 8'h00;
    endproperty
    a_coll_default: assert property (p_coll_default) else $error("collision not reset");

    property p_conv_store;
        i_evt.conv_valid |=> conv_reg == $past(i_evt.conv_data);
    endproperty
    a_conv_store: assert property (p_conv_store) else $error("conversion not stored");

    property p_high_keep;
        !wr_high && !i_cmd_set_default |=> $stable(o_tx.tx_length[9:2]);
    endproperty
    a_high_keep: assert property (p_high_keep) else $error("length high changed");

    property p_low_keep;
        !wr_low && !i_cmd_set_default && !i_evt.tx_done |=> $stable(txl_reg);
    endproperty
    a_low_keep: assert property (p_low_keep) else $error("length low changed");

    c_overflow: cover property (fifo_fill == 6'h20 && i_evt.fifo_push ##1 fifo_ovr);
    c_collision: cover property (i_evt.collision ##1 i_reg.rd);
    c_flags_done: cover property (o_tx.anticoll_frame && i_evt.tx_done);
    c_rx_frame: cover property (i_evt.rx_start ##[1:20] i_evt.rx_end);
    c_default_conv: cover property (i_cmd_set_default && conv_reg != 8'h00);
endmodule
`default_nettype wire

/* File: verilog/rfs_regs.svh */
// Register offsets, field positions, reset values and limits of the framing status bank
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

`define RFS_OFF_FIFO_STATE 6'h09
`define RFS_OFF_COLLISION 6'h0a
`define RFS_OFF_TX_LEN_LOW 6'h0b
`define RFS_OFF_TX_LEN_HIGH 6'h0c
`define RFS_OFF_CONV_RESULT 6'h0d

`define RFS_RST_FIFO_STATE 8'h00
`define RFS_RST_COLLISION 8'h00
`define RFS_RST_TX_LEN_LOW 8'h00
`define RFS_RST_TX_LEN_HIGH 8'h00
`define RFS_RST_CONV_RESULT 8'h00
`define RFS_RD_UNMAPPED 8'h00

`define RFS_FIFO_ACTIVE_BIT 0
`define RFS_FIFO_OVR_BIT 1
`define RFS_FIFO_CNT_LSB 2
`define RFS_FIFO_CNT_MSB 7
`define RFS_COLL_BYTES_LSB 4
`define RFS_COLL_BYTES_MSB 7
`define RFS_COLL_BITS_LSB 1
`define RFS_COLL_BITS_MSB 3
`define RFS_TXL_ANTICOLL_BIT 0
`define RFS_TXL_NIBBLE_BIT 1
`define RFS_TXL_SPLIT_LSB 3
`define RFS_TXL_SPLIT_MSB 5
`define RFS_TXL_LOWER_LSB 6
`define RFS_TXL_LOWER_MSB 7
`define RFS_TXL_WR_MASK 8'hfb

`define RFS_FIFO_DEPTH 32
`define RFS_TX_LEN_MAX 1023

`endif

/* File: verilog/rfs_pkg.sv */
// Types shared by the framing status register bank
`default_nettype none
package rfs_pkg;

    typedef struct packed {
        logic [5:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rfs_reg_req_t;

    typedef struct packed {
        logic rx_start;
        logic rx_end;
        logic fifo_push;
        logic fifo_pop;
        logic collision;
        logic [3:0] coll_bytes;
        logic [2:0] coll_bits;
        logic tx_done;
        logic conv_valid;
        logic [7:0] conv_data;
    } rfs_frame_evt_t;

    typedef struct packed {
        logic [9:0] tx_length;
        logic [2:0] split_byte_bits;
        logic nibble_reply_expected;
        logic anticoll_frame;
    } rfs_tx_setup_t;

    typedef enum logic [1:0] {
        RFS_RX_IDLE = 2'b01,
        RFS_RX_BUSY = 2'b10
    } rfs_rx_state_t;

endpackage
`default_nettype wire

/* File: verilog/rfs_fifo_track.sv */
// Receive activity, FIFO fill count and overflow tracking
`timescale 1ns/10ps
`default_nettype none
module rfs_fifo_track #(
    parameter int DEPTH = 32,
    parameter int CW = 6
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_rx_start,
    input wire logic i_rx_end,
    input wire logic i_push,
    input wire logic i_pop,
    output logic o_rx_active,
    output logic [CW-1:0] o_fill,
    output logic o_overflow
);
    import rfs_pkg::*;

    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    rfs_rx_state_t state_reg, state_next;
    logic [CW-1:0] fill_reg, fill_next;
    logic ovr_reg, ovr_next;

    always_comb begin
        state_next = state_reg;
        fill_next = fill_reg;
        ovr_next = ovr_reg;
        // Clear first so a same-cycle event still lands
        if (i_clear) begin
            state_next = RFS_RX_IDLE;
            fill_next = '0;
            ovr_next = 1'b0;
        end
        case (state_next)
            RFS_RX_IDLE: begin
                if (i_rx_start) begin
                    state_next = RFS_RX_BUSY;
                end
            end
            RFS_RX_BUSY: begin
                if (i_rx_end) begin
                    state_next = RFS_RX_IDLE;
                end
            end
            default: begin
                state_next = RFS_RX_IDLE;
            end
        endcase
        if (i_push && !i_pop) begin
            if (fill_next == FULL) begin
                ovr_next = 1'b1;
            end else begin
                fill_next = fill_next + 1'b1;
            end
        end else if (i_pop && !i_push && fill_next != '0) begin
            fill_next = fill_next - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= RFS_RX_IDLE;
            fill_reg <= '0;
            ovr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fill_reg <= fill_next;
            ovr_reg <= ovr_next;
        end
    end

    // Busy is the upper one-hot bit, so the output is a bare flop
    assign o_rx_active = state_reg[1];
    assign o_fill = fill_reg;
    assign o_overflow = ovr_reg;
endmodule
`default_nettype wire

/* File: testbench/rfs_host_model.sv */
// Host side model driving the register strobe port of the framing status bank
`timescale 1ns/10ps
`default_nettype none
module rfs_host_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output rfs_pkg::rfs_reg_req_t o_reg
);
    import rfs_pkg::*;

    initial o_reg = '0;

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        #1;
        o_reg.addr = a;
        o_reg.wdata = d;
        o_reg.wr = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_reg.wr = 1'b0;
        // Idle bus must not look like the last write
        o_reg.wdata = ~d;
        o_reg.addr = ~a;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
        @(posedge i_sys_clk);
        #1;
        o_reg.addr = a;
        o_reg.rd = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_reg.rd = 1'b0;
        o_reg.addr = ~a;
        d = i_rdata;
        v = i_rvalid;
    endtask

    // Length is clamped, never above the supported maximum
    task automatic tx_setup(input int len, input logic [2:0] bits, input logic nib,
                            input logic ac);
        logic [9:0] l;
        l = (len > 1023) ? 10'h3ff : len[9:0];
        wr(6'h0c, l[9:2]);
        wr(6'h0b, {l[1:0], bits, 1'b0, nib, ac});
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_rfs_status_regs.sv */
// Self-checking bench for the framing status register bank
`timescale 1ns/10ps
`default_nettype none
`include "rfs_regs.svh"
module tb_rfs_status_regs;
    import rfs_pkg::*;

    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic cmd_def = 1'b0;
    logic cmd_clr = 1'b0;
    rfs_frame_evt_t evt = '0;
    rfs_reg_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    rfs_tx_setup_t tx;
    logic rx_active;
    logic [5:0] fill;
    logic ovr;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    rfs_status_regs rfs_status_regs_inst (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg(req),
        .i_cmd_set_default(cmd_def), .i_cmd_clear(cmd_clr), .i_evt(evt),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_tx(tx), .o_rx_active(rx_active),
        .o_fifo_fill(fill), .o_fifo_overflow(ovr)
    );

    rfs_host_model rfs_host_model_inst (
        .i_sys_clk(i_sys_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_reg(req)
    );

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        rfs_host_model_inst.rd(a, d, v);
        chk({15'h0, v}, 16'h0001, "read answer strobe");
        chk({8'h0, d}, {8'h0, exp}, "read data");
        // The answer strobe must not outlive its cycle
        @(posedge i_sys_clk);
        #1;
        chk({15'h0, rvalid}, 16'h0000, "read answer one cycle");
    endtask

    task automatic ev(input rfs_frame_evt_t e);
        @(posedge i_sys_clk);
        #1;
        evt = e;
        @(posedge i_sys_clk);
        #1;
        evt = '0;
    endtask

    task automatic cmd(input logic dflt);
        @(posedge i_sys_clk);
        #1;
        if (dflt) cmd_def = 1'b1; else cmd_clr = 1'b1;
        @(posedge i_sys_clk);
        #1;
        cmd_def = 1'b0;
        cmd_clr = 1'b0;
    endtask

    task automatic fifo_n(input int n, input logic push);
        rfs_frame_evt_t e;
        e = '0;
        e.fifo_push = push;
        e.fifo_pop = ~push;
        repeat (n) ev(e);
    endtask

    task automatic t_reset_values();
        for (int a = 9; a <= 14; a++) begin
            rd_chk(a[5:0], 8'h00);
        end
    endtask

    task automatic t_fifo_and_collision();
        rfs_frame_evt_t e;
        e = '0;
        e.rx_start = 1'b1;
        ev(e);
        chk({15'h0, rx_active}, 16'h0001, "receive active after start");
        fifo_n(32, 1'b1);
        chk({9'h0, ovr, fill}, 16'h0020, "full without overflow");
        fifo_n(1, 1'b1);
        chk({9'h0, ovr, fill}, 16'h0060, "overflow at full");
        rd_chk(`RFS_OFF_FIFO_STATE, 8'h83);
        fifo_n(33, 1'b0);
        rd_chk(`RFS_OFF_FIFO_STATE, 8'h03);
        e = '0;
        e.rx_end = 1'b1;
        ev(e);
        rd_chk(`RFS_OFF_FIFO_STATE, 8'h02);
        e = '0;
        e.collision = 1'b1;
        e.coll_bytes = 4'h9;
        e.coll_bits = 3'h5;
        ev(e);
        rfs_host_model_inst.wr(`RFS_OFF_COLLISION, 8'hff);
        rd_chk(`RFS_OFF_COLLISION, 8'h9a);
        cmd(1'b0);
        rd_chk(`RFS_OFF_FIFO_STATE, 8'h00);
        rd_chk(`RFS_OFF_COLLISION, 8'h00);
    endtask

    task automatic t_transmit_setup();
        rfs_frame_evt_t e;
        rfs_host_model_inst.tx_setup(645, 3'b101, 1'b0, 1'b1);
        chk({tx.tx_length, tx.split_byte_bits, tx.nibble_reply_expected, tx.anticoll_frame, 1'b0},
            {10'd645, 3'b101, 1'b0, 1'b1, 1'b0}, "transmit setup outputs");
        rd_chk(`RFS_OFF_TX_LEN_HIGH, 8'ha1);
        rfs_host_model_inst.wr(`RFS_OFF_TX_LEN_LOW, 8'hff);
        rd_chk(`RFS_OFF_TX_LEN_LOW, 8'hfb);
        chk({6'h0, tx.tx_length}, 16'h0287, "length low bits");
        e = '0;
        e.tx_done = 1'b1;
        ev(e);
        chk({14'h0, tx.nibble_reply_expected, tx.anticoll_frame}, 16'h0, "flags after send");
        rd_chk(`RFS_OFF_TX_LEN_LOW, 8'hf8);
    endtask

    task automatic t_converter();
        rfs_frame_evt_t e;
        e = '0;
        e.conv_valid = 1'b1;
        e.conv_data = 8'ha5;
        ev(e);
        rfs_host_model_inst.wr(`RFS_OFF_CONV_RESULT, 8'h00);
        cmd(1'b0);
        rd_chk(`RFS_OFF_CONV_RESULT, 8'ha5);
        cmd(1'b1);
        rd_chk(`RFS_OFF_CONV_RESULT, 8'h00);
        rd_chk(`RFS_OFF_TX_LEN_LOW, 8'h00);
        rd_chk(`RFS_OFF_TX_LEN_HIGH, 8'h00);
    endtask

    // Reset pulled mid-run must wipe state that is not zero
    task automatic t_mid_reset();
        rfs_frame_evt_t e;
        e = '0;
        e.rx_start = 1'b1;
        e.fifo_push = 1'b1;
        ev(e);
        rfs_host_model_inst.tx_setup(1100, 3'b111, 1'b1, 1'b1);
        chk({tx.tx_length, tx.split_byte_bits, tx.nibble_reply_expected, tx.anticoll_frame, 1'b0},
            {10'h3ff, 3'b111, 1'b1, 1'b1, 1'b0}, "clamped setup");
        @(posedge i_sys_clk);
        #1;
        i_rst_b = 1'b0;
        @(posedge i_sys_clk);
        #1;
        chk({tx.tx_length, tx.split_byte_bits, tx.nibble_reply_expected, tx.anticoll_frame,
            rx_active}, 16'h0000, "outputs in reset");
        chk({9'h0, ovr, fill}, 16'h0000, "fifo in reset");
        i_rst_b = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        rd_chk(`RFS_OFF_FIFO_STATE, 8'h00);
        rd_chk(`RFS_OFF_TX_LEN_LOW, 8'h00);
        rd_chk(`RFS_OFF_TX_LEN_HIGH, 8'h00);
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        repeat (16) @(posedge i_sys_clk);
        #1;
        i_rst_b = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        t_reset_values();
        t_fifo_and_collision();
        t_transmit_setup();
        t_converter();
        t_mid_reset();
        close_out();
    end
endmodule
`default_nettype wire
